/* hdl/byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : byte_fifo
`default_nettype wire

/* hdl/caller_id_tone_fsk_receiver_ctrl.sv */
// What this block does
// [R1] Pair present/absent guards timed like alert tone, from guard regs.
// [R2] On decoded tone pair raise valid bit, key code in result low nibble.
// [R3] Valid rising edge sets sticky flag; only software clears it.
// [R4] Mode bit 4 of column config: 0 decoder, 1 in-band tone detector.
// [R5] Tone-detector mode: group-seen bits follow band presence immediately.
// [R6] Carrier bit rises after 8 ms presence, falls after over 8 ms absence.
// [R7] Demodulated bit shown at 1200 baud with matching bit clock.
// [R8] After eight bits load byte register and set byte-ready; design queues byte in buffer, register shows oldest unread byte.
// [R9] Byte-ready rising edge sets flag and interrupt; software clears it.
// [R10] Data latched into indexed tuning register on rising strobe bit 4.
// [R11] Indices 0 to 5 map the six tuning registers.
// [R12] Software should load suggested tuning values (far side).
// [R13] Row tolerance: upper nibble zero, codes select 0.6/2.5/3.5 percent.
// [R14] Column tolerance codes select 0.5/1.5/2.5 percent; bits 2,3 reserved.
// [R15] Present-guard counts up; bit 5 makes frequency change restart it.
// [R16] Absent-guard up/down, or up-and-pause when config bit 6 set.
// [R17] Gain nibbles choose step 0..10, step 5 is 0 dB.
// [R18] Hysteresis nibbles set base plus 3 mV per step.
// [R19] Guard timer ticks 0.858 ms, restarts at zero, stops at threshold.
// [R20] Each receiver runs only with its enable and global enable set.
// [R21] Strobe with index 6 or 7 changes no tuning register.
`timescale 1ns/1ps
`default_nettype none
module caller_id_tone_fsk_receiver_ctrl
   import cid_pkg::*;
#(
   parameter int unsigned GUARD_TICK   = GUARD_TICK_CYC,
   parameter int unsigned CARRIER_HYST = CARRIER_HYST_CYC,
   parameter int unsigned BAUD_DIV     = BAUD_CYC,
   parameter int unsigned FIFO_DEPTH   = 16
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        caller_ident_global_enable,
   input  wire logic        tone_pair_receiver_enable,
   input  wire logic        fsk_decoder_enable,
   input  wire logic [7:0]  pair_present_guard,
   input  wire logic [7:0]  pair_absent_guard,
   input  wire logic [7:0]  tuning_data,
   input  wire logic [7:0]  tuning_index_strobe,
   input  wire tone_front_t tone_in,
   input  wire fsk_front_t  fsk_in,
   input  wire logic        tone_flag_clear,
   input  wire logic        byte_flag_clear,
   input  wire logic        byte_pop,
   output var  logic [7:0]  tone_result_reg,
   output var  logic        tone_pair_valid_flag,
   output var  logic        carrier_present,
   output var  logic        demod_bit,
   output var  logic        demod_bit_clock,
   output var  logic        byte_ready,
   output var  logic        byte_ready_flag,
   output var  logic        caller_ident_interrupt_flag,
   output var  logic [7:0]  demod_byte_reg,
   output var  logic        byte_avail,
   output var  logic        byte_overrun,
   output var  logic [7:0]  row_tolerance_cfg,
   output var  logic [7:0]  column_tolerance_mode_cfg,
   output var  logic [7:0]  gain_alert_fsk,
   output var  logic [7:0]  gain_tone_pair,
   output var  logic [7:0]  hysteresis_alert_tone_pair,
   output var  logic [7:0]  hysteresis_fsk_filter
);
   function automatic logic [3:0] clamp_step(input logic [3:0] s);
      return (s > GAIN_STEP_MAX) ? GAIN_STEP_MAX : s;
   endfunction : clamp_step

   // Front-end lines come from analogue detectors: two-stage synchronise
   tone_front_t tone_s1_q, tone_s2_q;
   fsk_front_t  fsk_s1_q, fsk_s2_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tone_s1_q <= '0;
         tone_s2_q <= '0;
         fsk_s1_q  <= '0;
         fsk_s2_q  <= '0;
      end else begin
         tone_s1_q <= tone_in;
         tone_s2_q <= tone_s1_q;
         fsk_s1_q  <= fsk_in;
         fsk_s2_q  <= fsk_s1_q;
      end
   end

   logic tone_run, fsk_run;
   assign tone_run = caller_ident_global_enable
                     && tone_pair_receiver_enable; // see [R20]
   assign fsk_run  = caller_ident_global_enable
                     && fsk_decoder_enable; // see [R20]

   // Tuning registers
   logic strobe_prev_q;
   logic strobe_rise;
   logic [2:0] idx;
   assign idx = tuning_index_strobe[2:0];
   assign strobe_rise = tuning_index_strobe[IDX_STROBE_BIT] && !strobe_prev_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         strobe_prev_q              <= 1'b0;
         row_tolerance_cfg          <= TUNING_RESET;
         column_tolerance_mode_cfg  <= TUNING_RESET;
         gain_alert_fsk             <= TUNING_RESET;
         gain_tone_pair             <= TUNING_RESET;
         hysteresis_alert_tone_pair <= TUNING_RESET;
         hysteresis_fsk_filter      <= TUNING_RESET;
      end else begin
         strobe_prev_q <= tuning_index_strobe[IDX_STROBE_BIT];
         if (strobe_rise) begin // see [R10]
            unique case (idx) // see [R11]
               IDX_ROW_TOL:  row_tolerance_cfg <= {4'h0, tuning_data[3:0]}; // see [R13]
               IDX_COL_MODE: column_tolerance_mode_cfg <= tuning_data; // see [R14]
               IDX_GAIN_AF:  gain_alert_fsk <= {clamp_step(tuning_data[7:4]),
                                                clamp_step(tuning_data[3:0])}; // see [R17]
               IDX_GAIN_TP:  gain_tone_pair <= {clamp_step(tuning_data[7:4]),
                                                clamp_step(tuning_data[3:0])}; // see [R17]
               IDX_HYST_ATP: hysteresis_alert_tone_pair <= tuning_data; // see [R18]
               IDX_HYST_FF:  hysteresis_fsk_filter <= tuning_data; // see [R18]
               default: ; // Indices 6 and 7 write nothing, see [R21]
            endcase
         end
      end
   end

   logic tone_mode, pt_restart, at_pause;
   assign tone_mode  = column_tolerance_mode_cfg[MODE_TONE_BIT]; // see [R4]
   assign pt_restart = column_tolerance_mode_cfg[PT_RESTART_BIT];
   assign at_pause   = column_tolerance_mode_cfg[AT_PAUSE_BIT];

   // Guard-time tick divider
   localparam int unsigned TW = $clog2(GUARD_TICK + 1);
   logic [TW-1:0] tick_cnt_q;
   logic          tick;
   assign tick = (tick_cnt_q == TW'(GUARD_TICK - 1));
   always_ff @(posedge core_clk) begin
      if (rst || !tone_run) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1; // see [R19]
      end
   end

   // Guard timing of the tone pair
   logic       pair_det, pair_det_q, valid_q;
   logic [7:0] pt_cnt_q, at_cnt_q;
   logic [3:0] key_prev_q;
   logic       key_change;
   assign pair_det   = tone_run && !tone_mode && tone_s2_q.tone_pair_present;
   assign key_change = pair_det && pair_det_q
                       && (tone_s2_q.key_code != key_prev_q);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pair_det_q <= 1'b0;
         key_prev_q <= 4'h0;
         pt_cnt_q   <= 8'h00;
         at_cnt_q   <= 8'h00;
         valid_q    <= 1'b0;
      end else begin
         pair_det_q <= pair_det;
         key_prev_q <= tone_s2_q.key_code;
         if (!valid_q) begin // see [R1]
            at_cnt_q <= 8'h00;
            if ((pair_det && !pair_det_q) || (key_change && pt_restart)) begin
               pt_cnt_q <= 8'h00; // see [R15]
            end else if (pair_det && pt_cnt_q == pair_present_guard) begin
               valid_q <= 1'b1; // see [R19]
            end else if (pair_det && tick) begin
               pt_cnt_q <= pt_cnt_q + 8'h01; // see [R15]
            end
         end else begin
            pt_cnt_q <= 8'h00;
            if (!pair_det && at_cnt_q == pair_absent_guard) begin
               valid_q <= 1'b0; // see [R1]
            end else if (tick) begin
               if (!pair_det) begin
                  at_cnt_q <= at_cnt_q + 8'h01; // see [R16]
               end else if (!at_pause && at_cnt_q != 8'h00) begin
                  at_cnt_q <= at_cnt_q - 8'h01; // see [R16]
               end
            end
         end
      end
   end

   // Tone result and flag
   logic valid_prev_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         valid_prev_q         <= 1'b0;
         tone_result_reg      <= 8'h00;
         tone_pair_valid_flag <= 1'b0;
      end else begin
         valid_prev_q <= valid_q;
         tone_result_reg[RES_VALID_BIT] <= valid_q; // see [R2]
         tone_result_reg[6] <= 1'b0;
         tone_result_reg[RES_HIGH_SEEN_BIT] <= tone_run && tone_mode
                                               && tone_s2_q.high_group_seen; // see [R5]
         tone_result_reg[RES_LOW_SEEN_BIT]  <= tone_run && tone_mode
                                               && tone_s2_q.low_group_seen; // see [R5]
         if (valid_q && !valid_prev_q) begin
            tone_result_reg[3:0] <= tone_s2_q.key_code; // see [R2]
         end
         if (valid_q && !valid_prev_q) begin
            tone_pair_valid_flag <= 1'b1; // Set wins over clear, see [R3]
         end else if (tone_flag_clear) begin
            tone_pair_valid_flag <= 1'b0; // see [R3]
         end
      end
   end

   // Carrier detect with hysteresis, one cycle longer to fall than to rise
   localparam int unsigned CW = $clog2(CARRIER_HYST + 2);
   logic [CW-1:0] car_cnt_q;
   logic          energy;
   assign energy = fsk_run && fsk_s2_q.band_energy;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         car_cnt_q       <= '0;
         carrier_present <= 1'b0;
      end else if (energy == carrier_present) begin
         car_cnt_q <= '0;
      end else if (!carrier_present && car_cnt_q == CW'(CARRIER_HYST - 1)) begin
         carrier_present <= 1'b1; // see [R6]
         car_cnt_q       <= '0;
      end else if (carrier_present && car_cnt_q == CW'(CARRIER_HYST)) begin
         carrier_present <= 1'b0; // Strictly more than 8 ms, see [R6]
         car_cnt_q       <= '0;
      end else begin
         car_cnt_q <= car_cnt_q + 1'b1;
      end
   end

   // Bit demodulation: sample at each front-end bit strobe, clock high half
   localparam int unsigned BW = $clog2(BAUD_DIV + 1);
   logic [BW-1:0] baud_cnt_q;
   logic          strobe_prev2_q, bit_take;
   logic [2:0]    bit_cnt_q;
   logic [7:0]    shift_q;
   logic          byte_push;
   assign bit_take = fsk_run && carrier_present
                     && fsk_s2_q.bit_strobe && !strobe_prev2_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         strobe_prev2_q  <= 1'b0;
         baud_cnt_q      <= '0;
         demod_bit       <= 1'b0;
         demod_bit_clock <= 1'b0;
         bit_cnt_q       <= 3'h0;
         shift_q         <= 8'h00;
         byte_push       <= 1'b0;
      end else begin
         strobe_prev2_q <= fsk_s2_q.bit_strobe;
         byte_push      <= 1'b0;
         if (bit_take) begin
            demod_bit       <= fsk_s2_q.bit_value; // see [R7]
            demod_bit_clock <= 1'b1; // see [R7]
            baud_cnt_q      <= BW'(BAUD_DIV / 2);
            shift_q   <= {fsk_s2_q.bit_value, shift_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
               byte_push <= 1'b1; // see [R8]
            end
         end else if (baud_cnt_q != '0) begin
            baud_cnt_q <= baud_cnt_q - 1'b1;
            if (baud_cnt_q == BW'(1)) begin
               demod_bit_clock <= 1'b0;
            end
         end
         if (!fsk_run || !carrier_present) begin
            bit_cnt_q <= 3'h0; // Partial byte dropped at carrier loss
         end
      end
   end

   // Byte buffer between demodulator and register
   logic [7:0] fifo_data;
   logic       fifo_valid, fifo_in_ready, byte_ready_prev_q;
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_data   (shift_q),
      .in_valid  (byte_push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (byte_pop)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         demod_byte_reg    <= 8'h00;
         byte_ready        <= 1'b0;
         byte_ready_prev_q <= 1'b0;
         byte_avail        <= 1'b0;
         byte_overrun      <= 1'b0;
      end else begin
         demod_byte_reg    <= fifo_data; // see [R8]
         byte_ready        <= byte_push; // see [R8]
         byte_ready_prev_q <= byte_ready;
         byte_avail        <= fifo_valid;
         if (byte_push && !fifo_in_ready) begin
            byte_overrun <= 1'b1; // Full buffer: byte lost, sticky
         end else if (byte_flag_clear) begin
            byte_overrun <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         byte_ready_flag             <= 1'b0;
         caller_ident_interrupt_flag <= 1'b0;
      end else if (byte_ready && !byte_ready_prev_q) begin
         byte_ready_flag             <= 1'b1; // Set wins, see [R9]
         caller_ident_interrupt_flag <= 1'b1; // see [R9]
      end else if (byte_flag_clear) begin
         byte_ready_flag             <= 1'b0; // see [R9]
         caller_ident_interrupt_flag <= 1'b0;
      end
   end
endmodule : caller_id_tone_fsk_receiver_ctrl
`default_nettype wire

/* hdl/cid_pkg.sv */
package cid_pkg;
   // Core clock and guard-timer tick
   localparam int unsigned CLK_HZ           = 250_000_000;
   localparam int unsigned GUARD_TICK_PS    = 858_000_000;
   localparam int unsigned CLK_PERIOD_PS    = 4_000;
   localparam int unsigned GUARD_TICK_CYC   = GUARD_TICK_PS / CLK_PERIOD_PS;
   // Carrier hysteresis
   localparam int unsigned CARRIER_HYST_US  = 8_000;
   localparam int unsigned CARRIER_HYST_CYC = CARRIER_HYST_US * 250;
   // Baud rate
   localparam int unsigned BAUD_HZ          = 1200;
   localparam int unsigned BAUD_CYC         = CLK_HZ / BAUD_HZ;

   // Internal tuning register indices
   localparam logic [2:0] IDX_ROW_TOL   = 3'h0;
   localparam logic [2:0] IDX_COL_MODE  = 3'h1;
   localparam logic [2:0] IDX_GAIN_AF   = 3'h2;
   localparam logic [2:0] IDX_GAIN_TP   = 3'h3;
   localparam logic [2:0] IDX_HYST_ATP  = 3'h4;
   localparam logic [2:0] IDX_HYST_FF   = 3'h5;
   localparam int unsigned NUM_TUNING   = 6;

   // Field positions
   localparam int unsigned IDX_STROBE_BIT   = 4;
   localparam int unsigned MODE_TONE_BIT    = 4;
   localparam int unsigned PT_RESTART_BIT   = 5;
   localparam int unsigned AT_PAUSE_BIT     = 6;
   localparam int unsigned RES_LOW_SEEN_BIT = 4;
   localparam int unsigned RES_HIGH_SEEN_BIT= 5;
   localparam int unsigned RES_VALID_BIT    = 7;

   localparam logic [7:0] TUNING_RESET  = 8'h00;
   localparam logic [3:0] GAIN_STEP_MAX = 4'hA;

   typedef struct packed {
      logic       tone_pair_present;
      logic [3:0] key_code;
      logic       low_group_seen;
      logic       high_group_seen;
   } tone_front_t;

   typedef struct packed {
      logic band_energy;
      logic bit_value;
      logic bit_strobe;
   } fsk_front_t;
endpackage : cid_pkg

/* testbench/cid_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cid_checker
   import cid_pkg::*;
#(
   parameter int unsigned CARRIER_HYST = 50
) (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [7:0]  tuning_data,
   input wire logic [7:0]  tuning_index_strobe,
   input wire logic        tone_flag_clear,
   input wire fsk_front_t  fsk_in,
   input wire logic [7:0]  tone_result_reg,
   input wire logic        tone_pair_valid_flag,
   input wire logic        carrier_present,
   input wire logic        demod_bit,
   input wire logic        demod_bit_clock,
   input wire logic        byte_ready,
   input wire logic        byte_ready_flag,
   input wire logic        caller_ident_interrupt_flag,
   input wire logic [7:0]  row_tolerance_cfg,
   input wire logic [7:0]  column_tolerance_mode_cfg,
   input wire logic [7:0]  gain_alert_fsk,
   input wire logic [7:0]  gain_tone_pair,
   input wire logic [7:0]  hysteresis_alert_tone_pair,
   input wire logic [7:0]  hysteresis_fsk_filter
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic [47:0] all_regs = {row_tolerance_cfg, column_tolerance_mode_cfg,
      gain_alert_fsk, gain_tone_pair, hysteresis_alert_tone_pair,
      hysteresis_fsk_filter};
   // Raw line counts; the design syncs late, so its own count is never longer
   logic [15:0] pres_q;
   logic [15:0] abs_q;
   always_ff @(posedge core_clk) begin
      if (rst || !fsk_in.band_energy) pres_q <= 16'h0000;
      else if (pres_q != 16'hFFFF) pres_q <= pres_q + 16'h0001;
   end
   always_ff @(posedge core_clk) begin
      if (rst || fsk_in.band_energy) abs_q <= 16'h0000;
      else if (abs_q != 16'hFFFF) abs_q <= abs_q + 16'h0001;
   end
   property p_tone_flag_set; $rose(tone_result_reg[7]) |-> ##[0:1] tone_pair_valid_flag; endproperty
   a_tone_flag_set: assert property (p_tone_flag_set)
      else $error("tone flag not set");
   property p_tone_flag_hold; tone_pair_valid_flag && !tone_flag_clear |=> tone_pair_valid_flag; endproperty
   a_tone_flag_hold: assert property (p_tone_flag_hold)
      else $error("tone flag lost");
   property p_byte_flag; byte_ready |=> byte_ready_flag && caller_ident_interrupt_flag; endproperty
   a_byte_flag: assert property (p_byte_flag)
      else $error("byte flag or interrupt missing");
   property p_byte_pulse; byte_ready |=> !byte_ready; endproperty
   a_byte_pulse: assert property (p_byte_pulse)
      else $error("byte ready too long");
   property p_bit_value; $rose(demod_bit_clock) |-> demod_bit == $past(fsk_in.bit_value, 3); endproperty
   a_bit_value: assert property (p_bit_value)
      else $error("demodulated bit wrong");
   property p_tuning_write; $rose(tuning_index_strobe[4]) && tuning_index_strobe[2:0] == IDX_HYST_ATP
      |=> hysteresis_alert_tone_pair == $past(tuning_data); endproperty
   a_tuning_write: assert property (p_tuning_write)
      else $error("tuning write lost");
   property p_tuning_idle; !$rose(tuning_index_strobe[4]) |=> $stable(all_regs); endproperty
   a_tuning_idle: assert property (p_tuning_idle)
      else $error("tuning reg changed without strobe");
   property p_bad_index; $rose(tuning_index_strobe[4]) && tuning_index_strobe[2:1] == 2'b11
      |=> $stable(all_regs); endproperty
   a_bad_index: assert property (p_bad_index)
      else $error("index 6 or 7 wrote a reg");
   property p_row_upper; row_tolerance_cfg[7:4] == 4'h0; endproperty
   a_row_upper: assert property (p_row_upper)
      else $error("row upper nibble set");
   property p_gain_step; gain_tone_pair[7:4] <= GAIN_STEP_MAX && gain_tone_pair[3:0] <= GAIN_STEP_MAX; endproperty
   a_gain_step: assert property (p_gain_step)
      else $error("gain step above range");
   property p_carrier_on; $rose(carrier_present) |-> pres_q >= CARRIER_HYST; endproperty
   a_carrier_on: assert property (p_carrier_on)
      else $error("carrier set early");
   property p_carrier_off; $fell(carrier_present) |-> abs_q >= CARRIER_HYST; endproperty
   a_carrier_off: assert property (p_carrier_off)
      else $error("carrier dropped early");
endmodule : cid_checker
bind caller_id_tone_fsk_receiver_ctrl cid_checker #(
   .CARRIER_HYST(CARRIER_HYST)
) cid_checker_inst (
   .core_clk(core_clk), .rst(rst), .tuning_data(tuning_data),
   .tuning_index_strobe(tuning_index_strobe), .fsk_in(fsk_in),
   .tone_flag_clear(tone_flag_clear), .tone_result_reg(tone_result_reg),
   .tone_pair_valid_flag(tone_pair_valid_flag), .demod_bit(demod_bit),
   .carrier_present(carrier_present), .demod_bit_clock(demod_bit_clock),
   .byte_ready(byte_ready), .byte_ready_flag(byte_ready_flag),
   .caller_ident_interrupt_flag(caller_ident_interrupt_flag),
   .row_tolerance_cfg(row_tolerance_cfg), .gain_alert_fsk(gain_alert_fsk),
   .column_tolerance_mode_cfg(column_tolerance_mode_cfg),
   .gain_tone_pair(gain_tone_pair), .hysteresis_fsk_filter(hysteresis_fsk_filter),
   .hysteresis_alert_tone_pair(hysteresis_alert_tone_pair)
);
`default_nettype wire

/* testbench/line_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module line_front_model
   import cid_pkg::*;
#(
   parameter int unsigned BIT_GAP = 24
) (
   input  wire logic        core_clk,
   input  wire logic        tone_on,
   input  wire logic [3:0]  key,
   input  wire logic        lo_on,
   input  wire logic        hi_on,
   input  wire logic        energy_on,
   input  wire logic        go,
   input  wire logic [7:0]  tx_byte,
   output var  tone_front_t tone_in,
   output var  fsk_front_t  fsk_in,
   output var  logic        busy
);
   logic [7:0]  sh_q = 8'h00;
   logic [3:0]  left_q = 4'h0;
   logic [3:0]  idle_key_q = 4'h5;
   int unsigned cnt_q = 0;
   logic        bit_q = 1'b0;
   logic        stb_q = 1'b0;
   // Undriven key and data lines wander, never hold the last value
   assign tone_in = {tone_on, tone_on ? key : idle_key_q, lo_on, hi_on};
   assign fsk_in = {energy_on, bit_q, stb_q};
   assign busy = (left_q != 4'h0);
   always_ff @(posedge core_clk) begin
      idle_key_q <= ~idle_key_q;
      if (left_q == 4'h0) begin
         bit_q <= ~bit_q;
         stb_q <= 1'b0;
         cnt_q <= 0;
         if (go) begin
            sh_q <= tx_byte;
            left_q <= 4'h8;
         end
      end else begin
         cnt_q <= (cnt_q == BIT_GAP - 1) ? 0 : cnt_q + 1;
         if (cnt_q == 0) bit_q <= sh_q[0];
         stb_q <= (cnt_q == 2);
         if (cnt_q == BIT_GAP - 1) begin
            sh_q <= sh_q >> 1;
            left_q <= left_q - 4'h1;
         end
      end
   end
endmodule : line_front_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import cid_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ge, te, fe, tclr, bclr, pop, m_tone, m_lo, m_hi, m_en, m_go;
   logic        tflag, carrier, dbit, dclk, brdy, bflag, irq, avail, ovr;
   logic        m_busy;
   logic [3:0]  m_key;
   logic [7:0]  pg, ag, tdata, tidx, res, dbyte, m_byte;
   logic [7:0]  cfg [6];
   tone_front_t tone_s;
   fsk_front_t  fsk_s;
   int          n_errors = 0;
   int          n_checks = 0;
   int          n, k;
   logic [7:0]  wv [8] = '{8'hF3, 8'h01, 8'h99, 8'hFC, 8'h35, 8'h33, 8'h55, 8'h66};
   logic [7:0]  ev [6] = '{8'h03, 8'h01, 8'h99, 8'hAA, 8'h35, 8'h33};

   always #2 core_clk = ~core_clk;

   caller_id_tone_fsk_receiver_ctrl #(.GUARD_TICK(10), .CARRIER_HYST(50),
      .BAUD_DIV(20), .FIFO_DEPTH(16)) caller_id_tone_fsk_receiver_ctrl_inst (
      .core_clk(core_clk), .rst(rst), .caller_ident_global_enable(ge),
      .tone_pair_receiver_enable(te), .fsk_decoder_enable(fe),
      .pair_present_guard(pg), .pair_absent_guard(ag), .tuning_data(tdata),
      .tuning_index_strobe(tidx), .tone_in(tone_s), .fsk_in(fsk_s),
      .tone_flag_clear(tclr), .byte_flag_clear(bclr), .byte_pop(pop),
      .tone_result_reg(res), .tone_pair_valid_flag(tflag),
      .carrier_present(carrier), .demod_bit(dbit), .demod_bit_clock(dclk),
      .byte_ready(brdy), .byte_ready_flag(bflag),
      .caller_ident_interrupt_flag(irq), .demod_byte_reg(dbyte),
      .byte_avail(avail), .byte_overrun(ovr), .row_tolerance_cfg(cfg[0]),
      .column_tolerance_mode_cfg(cfg[1]), .gain_alert_fsk(cfg[2]),
      .gain_tone_pair(cfg[3]), .hysteresis_alert_tone_pair(cfg[4]),
      .hysteresis_fsk_filter(cfg[5]));

   line_front_model #(.BIT_GAP(24)) line_front_model_inst (
      .core_clk(core_clk), .tone_on(m_tone), .key(m_key), .lo_on(m_lo),
      .hi_on(m_hi), .energy_on(m_en), .go(m_go), .tx_byte(m_byte),
      .tone_in(tone_s), .fsk_in(fsk_s), .busy(m_busy));

   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic write_tuning(input logic [2:0] idx, input logic [7:0] d);
      tdata = d;
      tidx = {5'h00, idx};
      tick();
      tidx[4] = 1'b1;
      tick();
      tidx[4] = 1'b0;
      tick();
   endtask : write_tuning

   function automatic logic [7:0] pat(input int i);
      return {i[3:0], ~i[3:0]};
   endfunction : pat

   task automatic final_report();
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   initial begin
      #(30000 * 4);
      n_errors++;
      final_report();
   end

   initial begin
      {ge, te, fe, tclr, bclr, pop, m_tone, m_lo, m_hi, m_en, m_go} = '0;
      pg = 8'h03;
      ag = 8'h03;
      tdata = 8'h00;
      tidx = 8'h00;
      m_key = 4'h9;
      m_byte = 8'h00;
      repeat (3) @(posedge core_clk);
      #1 rst = 1'b0;
      tick();
      for (k = 0; k < 6; k++) chk(cfg[k], TUNING_RESET);
      for (k = 0; k < 8; k++) write_tuning(k[2:0], wv[k]);
      for (k = 0; k < 6; k++) chk(cfg[k], ev[k]);
      // Receiver disabled: a tone must not be decoded
      m_tone = 1'b1;
      repeat (60) tick();
      chk({7'h0, res[7]}, 8'h00);
      ge = 1'b1;
      te = 1'b1;
      fe = 1'b1;
      for (n = 0; n < 300 && res[7] !== 1'b1; n++) tick();
      chk({7'h0, n >= 20 && n < 300}, 8'h01);
      chk({4'h0, res[3:0]}, 8'h09);
      chk({7'h0, tflag}, 8'h01);
      tclr = 1'b1;
      tick();
      tclr = 1'b0;
      tick();
      chk({7'h0, tflag}, 8'h00);
      m_tone = 1'b0;
      for (n = 0; n < 300 && res[7] !== 1'b0; n++) tick();
      chk({7'h0, n >= 20 && n < 300}, 8'h01);
      write_tuning(3'h1, 8'h21);
      m_tone = 1'b1;
      repeat (15) tick();
      m_key = 4'h5;
      for (n = 0; n < 300 && res[7] !== 1'b1; n++) tick();
      chk({7'h0, n >= 24 && n < 300}, 8'h01);
      write_tuning(3'h1, 8'h11);
      m_lo = 1'b1;
      repeat (4) tick();
      chk({2'h0, res[5:4], 4'h0}, 8'h10);
      m_lo = 1'b0;
      m_hi = 1'b1;
      repeat (4) tick();
      chk({2'h0, res[5:4], 4'h0}, 8'h20);
      m_en = 1'b1;
      for (n = 0; n < 300 && carrier !== 1'b1; n++) tick();
      chk({7'h0, n >= 50 && n < 300}, 8'h01);
      // Seventeen bytes unread: one more than the buffer holds
      for (k = 0; k < 17; k++) begin
         m_byte = pat(k);
         m_go = 1'b1;
         tick();
         m_go = 1'b0;
         for (n = 0; n < 400 && m_busy; n++) tick();
      end
      repeat (8) tick();
      chk({4'h0, avail, bflag, irq, ovr}, 8'h0F);
      for (k = 0; k < 16; k++) begin
         chk(dbyte, pat(k));
         pop = 1'b1;
         tick();
         pop = 1'b0;
         repeat (2) tick();
      end
      chk({7'h0, avail}, 8'h00);
      bclr = 1'b1;
      tick();
      bclr = 1'b0;
      tick();
      chk({5'h0, bflag, irq, ovr}, 8'h00);
      m_en = 1'b0;
      for (n = 0; n < 300 && carrier !== 1'b0; n++) tick();
      chk({7'h0, n >= 50 && n < 300}, 8'h01);
      final_report();
   end
endmodule : tb
`default_nettype wire
